// File: rtl/stbd_pkg.sv
/*
  stbd_pkg: shared constants and types for the compressed texel block decoder.
  Assumes: used as stbd_pkg::name, never imported.
*/
package stbd_pkg;

    // geometry of a block
    localparam int NPIX = 16;               // texels per 4x4 block
    localparam int IDX_W = 3;               // bits per texel index
    localparam int WORD_W = 64;             // bits per channel word
    localparam int BYTES_PER_WORD = 8;      // bytes per channel word
    localparam int BLOCK_W = 128;           // bits per input block

    // field positions inside a channel word
    localparam int BASE_MSB = 63;           // base value, top byte
    localparam int BASE_LSB = 56;
    localparam int MULT_MSB = 55;           // multiplier
    localparam int MULT_LSB = 52;
    localparam int TSEL_MSB = 51;           // modifier table select
    localparam int TSEL_LSB = 48;
    localparam int IDX_TOP = 47;            // first texel index msb

    // arithmetic constants
    localparam logic [7:0] BASE_FORBIDDEN = 8'h80;  // -128 encoding
    localparam logic [7:0] BASE_SUBST = 8'h81;      // -127 used instead
    localparam logic [2:0] SCALE_ZERO = 3'h0;       // low bits after x8, signed
    localparam logic [2:0] SCALE_HALF = 3'h4;       // low bits after x8 with +4
    localparam logic signed [13:0] SMAX = 14'sh03FF;  // +1023
    localparam logic signed [13:0] SMIN = -14'sh03FF; // -1023
    localparam logic signed [13:0] UMAX = 14'sh07FF;  // 2047
    localparam logic signed [13:0] UMIN = 14'sh0000;  // 0

    // all sixteen modifier tables, position 0 leftmost
    localparam logic [4:0] MOD_TBL [16][8] = '{
        '{5'h1D, 5'h1A, 5'h17, 5'h11, 5'h02, 5'h05, 5'h08, 5'h0E},
        '{5'h1D, 5'h19, 5'h16, 5'h13, 5'h02, 5'h06, 5'h09, 5'h0C},
        '{5'h1E, 5'h1B, 5'h18, 5'h13, 5'h01, 5'h04, 5'h07, 5'h0C},
        '{5'h1E, 5'h1C, 5'h1A, 5'h13, 5'h01, 5'h03, 5'h05, 5'h0C},
        '{5'h1D, 5'h1A, 5'h18, 5'h14, 5'h02, 5'h05, 5'h07, 5'h0B},
        '{5'h1D, 5'h19, 5'h17, 5'h15, 5'h02, 5'h06, 5'h08, 5'h0A},
        '{5'h1C, 5'h19, 5'h18, 5'h15, 5'h03, 5'h06, 5'h07, 5'h0A},
        '{5'h1D, 5'h1B, 5'h18, 5'h15, 5'h02, 5'h04, 5'h07, 5'h0A},
        '{5'h1E, 5'h1A, 5'h18, 5'h16, 5'h01, 5'h05, 5'h07, 5'h09},
        '{5'h1E, 5'h1B, 5'h18, 5'h16, 5'h01, 5'h04, 5'h07, 5'h09},
        '{5'h1E, 5'h1C, 5'h18, 5'h16, 5'h01, 5'h03, 5'h07, 5'h09},
        '{5'h1E, 5'h1B, 5'h19, 5'h16, 5'h01, 5'h04, 5'h06, 5'h09},
        '{5'h1D, 5'h1C, 5'h19, 5'h16, 5'h02, 5'h03, 5'h06, 5'h09},
        '{5'h1F, 5'h1E, 5'h1D, 5'h16, 5'h00, 5'h01, 5'h02, 5'h09},
        '{5'h1C, 5'h1A, 5'h18, 5'h17, 5'h03, 5'h05, 5'h07, 5'h08},
        '{5'h1D, 5'h1B, 5'h19, 5'h17, 5'h02, 5'h04, 5'h06, 5'h08}
    };

    // block formats
    typedef enum logic [1:0] {
        FMT_ONE_UNSIGNED,                   // one_channel_unsigned_block_format
        FMT_ONE_SIGNED,                     // one_channel_signed_block_format
        FMT_TWO_UNSIGNED,                   // two_channel_unsigned_block_format
        FMT_TWO_SIGNED                      // two channels, signed arithmetic
    } stbd_fmt_t;

    // one decoded block as it travels to the sampler
    typedef struct packed {
        stbd_fmt_t fmt;                     // format of this block
        logic [NPIX-1:0][10:0] red11;       // first channel, 11-bit
        logic [NPIX-1:0][10:0] grn11;       // second channel, 11-bit
        logic [NPIX-1:0][15:0] red16;       // first channel, widened
        logic [NPIX-1:0][15:0] grn16;       // second channel, widened
    } stbd_result_t;

endpackage

// File: rtl/stbd_stream_if.sv
/*
  stbd_stream_if: valid/ready carrier of decoded blocks between the decoder's modules.
  Assumes: one source and one sink on the same clock.
*/
interface stbd_stream_if;
    logic valid;                            // source holds a result
    logic ready;                            // sink can take it
    stbd_pkg::stbd_result_t data;           // decoded block

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// File: rtl/stbd_chan_decode.sv
/*
  stbd_chan_decode: combinational decode of one 64-bit channel word into sixteen texels.
  Assumes: word already assembled with the lowest-address byte in the top bits.
*/
module stbd_chan_decode (
    input wire logic [63:0] word,           // channel word
    input wire logic is_signed,             // signed arithmetic
    output logic [15:0][10:0] px11,         // clamped 11-bit results
    output logic [15:0][15:0] px16          // widened 16-bit results
);
    logic [7:0] base_code;                  // base byte after substitution
    logic signed [13:0] base_term;          // scaled base, shared datapath
    logic [3:0] mult;                       // multiplier field
    logic [3:0] tsel;                       // table select field

    // base term: signed x8, or unsigned x8 plus 4 via the low bits
    always_comb begin
        base_code = word[stbd_pkg::BASE_MSB:stbd_pkg::BASE_LSB];
        mult = word[stbd_pkg::MULT_MSB:stbd_pkg::MULT_LSB];
        tsel = word[stbd_pkg::TSEL_MSB:stbd_pkg::TSEL_LSB];
        if (is_signed) begin
            if (base_code == stbd_pkg::BASE_FORBIDDEN) begin
                base_code = stbd_pkg::BASE_SUBST;
            end
            // sign-extended shift by three, no offset
            base_term = {{3{base_code[7]}}, base_code, stbd_pkg::SCALE_ZERO};
        end else begin
            // unsigned: the +4 sits in the freed low bits
            base_term = {3'h0, base_code, stbd_pkg::SCALE_HALF};
        end
    end

    // one identical lane per texel
    genvar p;
    generate
        for (p = 0; p < stbd_pkg::NPIX; p++) begin : g_pix
            logic [2:0] idx;                // texel index
            logic signed [4:0] modv;        // selected modifier
            logic signed [9:0] prod;        // modifier x multiplier
            logic signed [13:0] third;      // third term
            logic signed [13:0] sum;        // unclamped value
            logic [10:0] res;               // clamped result
            logic [10:0] mag;               // magnitude of a signed result
            logic [15:0] wide;              // widened magnitude

            always_comb begin
                // leftmost index belongs to texel 0, msb on the higher bit
                idx = word[stbd_pkg::IDX_TOP - stbd_pkg::IDX_W * p -: 3];
                modv = $signed(stbd_pkg::MOD_TBL[tsel][idx]);
                prod = 10'(modv) * 10'($signed({1'b0, mult}));
                if (mult == 4'h0) begin
                    third = {{9{modv[4]}}, modv};
                end else begin
                    third = {prod[9], prod, 3'h0};
                end
                sum = base_term + third;
                // saturate to the format's range
                if (is_signed) begin
                    if (sum > stbd_pkg::SMAX) begin
                        sum = stbd_pkg::SMAX;
                    end else if (sum < stbd_pkg::SMIN) begin
                        sum = stbd_pkg::SMIN;
                    end
                end else begin
                    if (sum > stbd_pkg::UMAX) begin
                        sum = stbd_pkg::UMAX;
                    end else if (sum < stbd_pkg::UMIN) begin
                        sum = stbd_pkg::UMIN;
                    end
                end
                res = sum[10:0];
                px11[p] = res;
                // widening: signed goes through the magnitude
                mag = res[10] ? 11'(-res) : res;
                wide = {1'b0, mag[9:0], 5'h00} + {11'h000, mag[9:5]};
                if (!is_signed) begin
                    px16[p] = {res, res[10:6]};
                end else if (res[10]) begin
                    px16[p] = 16'(-wide);
                end else begin
                    px16[p] = wide;
                end
            end
        end
    endgenerate
endmodule

// File: rtl/stbd_pair_buf.sv
/*
  stbd_pair_buf: two-entry buffer of decoded blocks with valid/ready on both sides.
  Assumes: a stall by the sink must lose nothing; ce low freezes all state and handshakes.
*/
module stbd_pair_buf (
    input wire logic clk,                   // clock
    input wire logic sys_rst,               // synchronous reset
    input wire logic ce,                    // clock enable
    stbd_stream_if.snk in_s,                // from the decoder stage
    stbd_stream_if.src out_s                // to the sampler
);
    typedef struct packed {
        stbd_pkg::stbd_result_t [1:0] mem;  // two entries
        logic wr;                           // write slot
        logic rd;                           // read slot
        logic [1:0] cnt;                    // entries held
    } stbd_buf_state_t;

    stbd_buf_state_t buf_r;                 // registered state
    stbd_buf_state_t buf_nxt;               // next state
    logic push;                             // entry accepted
    logic pop;                              // entry delivered

    // handshakes: honest full and empty, gated by ce
    assign in_s.ready = ce && (buf_r.cnt != 2'h2);
    assign out_s.valid = ce && (buf_r.cnt != 2'h0);
    assign out_s.data = buf_r.mem[buf_r.rd];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    // next state of the buffer
    always_comb begin
        buf_nxt = buf_r;
        if (push) begin
            buf_nxt.mem[buf_r.wr] = in_s.data;
            buf_nxt.wr = !buf_r.wr;
        end
        if (pop) begin
            buf_nxt.rd = !buf_r.rd;
        end
        // count moves only when exactly one side acts
        if (push && !pop) begin
            buf_nxt.cnt = buf_r.cnt + 2'h1;
        end else if (pop && !push) begin
            buf_nxt.cnt = buf_r.cnt - 2'h1;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            buf_r <= '0;
        end else if (ce) begin
            buf_r <= buf_nxt;
        end
    end
endmodule

// File: rtl/stbd_decoder.sv
/*
  stbd_decoder: compressed 4x4 texel block decoder, top level.
  Takes a block from texture fetch, decodes one or two channel words, and hands
  the result to the sampler through a two-entry buffer.
  Assumes: fetch and sampler run on clk; byte k of in_block is in_block[8k+7:8k],
  byte 0 being the lowest memory address.
*/
// Behaviour
// - two-channel block is sixteen bytes, ascending
// - bytes pack into two words, earlier byte higher
// - first word red, second green, same decode
// - signed single block: eight bytes, one word
// - top sixteen bits header, low 48 indices
// - base is two's complement, -128 becomes -127
// - signed base scaled by eight, no offset
// - bits 51..48 choose one of sixteen tables
// - each texel's 3-bit index picks modifier, leftmost zero
// - table 13 is -1,-2,-3,-10,0,1,2,9
// - nonzero multiplier: modifier times multiplier, times eight
// - zero multiplier: third term is modifier alone
// - signed sum clamps to -1023..1023, 11 bits
// - non-negative widening: x<<5 plus x>>5
// - negative widening goes through the magnitude
// - wider sizes allowed, never below eleven bits
// - one datapath serves signed and unsigned
// - unsigned: x8 plus 4, clamp 0..2047, x>>6
module stbd_decoder (
    input wire logic clk,                   // clock, 50 MHz
    input wire logic sys_rst,               // synchronous reset, active high
    input wire logic ce,                    // clock enable, freezes all state
    input wire logic in_valid,              // block offered by fetch
    output logic in_ready,                  // block taken this cycle
    input wire stbd_pkg::stbd_fmt_t in_fmt, // format of the offered block
    input wire logic [127:0] in_block,      // block bytes, byte 0 lowest
    output logic out_valid,                 // decoded block available
    input wire logic out_ready,             // sampler takes it
    output stbd_pkg::stbd_fmt_t out_fmt,    // format of the decoded block
    output logic [15:0][10:0] out_red11,    // first channel, 11-bit
    output logic [15:0][10:0] out_grn11,    // second channel, 11-bit
    output logic [15:0][15:0] out_red16,    // first channel, 16-bit
    output logic [15:0][15:0] out_grn16     // second channel, 16-bit
);
    typedef struct packed {
        logic valid;                        // stage holds a block
        stbd_pkg::stbd_fmt_t fmt;           // its format
        logic [63:0] w_red;                 // first_channel_word
        logic [63:0] w_grn;                 // second_channel_word
    } stbd_stage_t;

    stbd_stage_t stg_r;                     // registered stage
    stbd_stage_t stg_nxt;                   // next stage
    logic [63:0] asm_red;                   // assembled first word
    logic [63:0] asm_grn;                   // assembled second word
    logic take;                             // block accepted
    logic drain;                            // stage handed to buffer
    logic fmt_signed;                       // stage uses signed arithmetic
    logic fmt_two;                          // stage holds two channels
    logic [15:0][10:0] red11;               // decoded first channel
    logic [15:0][10:0] grn11;               // decoded second channel
    logic [15:0][15:0] red16;               // widened first channel
    logic [15:0][15:0] grn16;               // widened second channel

    stbd_stream_if dec_s ();                // stage to buffer
    stbd_stream_if out_s ();                // buffer to ports

    // byte assembly: lowest address lands in the top byte of each word
    genvar k;
    generate
        for (k = 0; k < stbd_pkg::BYTES_PER_WORD; k++) begin : g_byte
            assign asm_red[63 - 8 * k -: 8] = in_block[8 * k +: 8];
            assign asm_grn[63 - 8 * k -: 8] = in_block[64 + 8 * k +: 8];
        end
    endgenerate

    // format decode of the held block
    always_comb begin
        fmt_signed = (stg_r.fmt == stbd_pkg::FMT_ONE_SIGNED)
            || (stg_r.fmt == stbd_pkg::FMT_TWO_SIGNED);
        fmt_two = (stg_r.fmt == stbd_pkg::FMT_TWO_UNSIGNED)
            || (stg_r.fmt == stbd_pkg::FMT_TWO_SIGNED);
    end

    // handshakes of the input stage; a full stage moves on when the buffer takes it
    assign dec_s.valid = stg_r.valid;
    assign drain = dec_s.valid && dec_s.ready;
    assign in_ready = ce && (!stg_r.valid || dec_s.ready);
    assign take = in_valid && in_ready;

    // next state of the input stage
    always_comb begin
        stg_nxt = stg_r;
        if (drain) begin
            stg_nxt.valid = 1'b0;
        end
        if (take) begin
            stg_nxt.valid = 1'b1;
            stg_nxt.fmt = in_fmt;
            stg_nxt.w_red = asm_red;
            // single-channel blocks carry no second word
            if ((in_fmt == stbd_pkg::FMT_TWO_UNSIGNED)
                    || (in_fmt == stbd_pkg::FMT_TWO_SIGNED)) begin
                stg_nxt.w_grn = asm_grn;
            end else begin
                stg_nxt.w_grn = 64'h0000_0000_0000_0000;
            end
        end
    end

    // stage register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stg_r <= '0;
        end else if (ce) begin
            stg_r <= stg_nxt;
        end
    end

    // red channel lane
    stbd_chan_decode u_red (
        .word (stg_r.w_red),
        .is_signed (fmt_signed),
        .px11 (red11),
        .px16 (red16)
    );

    // green channel lane, same decode
    stbd_chan_decode u_grn (
        .word (stg_r.w_grn),
        .is_signed (fmt_signed),
        .px11 (grn11),
        .px16 (grn16)
    );

    // result bundle; green reads zero for single-channel blocks
    always_comb begin
        dec_s.data.fmt = stg_r.fmt;
        dec_s.data.red11 = red11;
        dec_s.data.red16 = red16;
        dec_s.data.grn11 = fmt_two ? grn11 : '0;
        dec_s.data.grn16 = fmt_two ? grn16 : '0;
    end

    // two-entry buffer absorbs sampler stalls
    stbd_pair_buf u_buf (
        .clk (clk),
        .sys_rst (sys_rst),
        .ce (ce),
        .in_s (dec_s),
        .out_s (out_s)
    );

    // output ports
    assign out_valid = out_s.valid;
    assign out_s.ready = out_ready;
    assign out_fmt = out_s.data.fmt;
    assign out_red11 = out_s.data.red11;
    assign out_grn11 = out_s.data.grn11;
    assign out_red16 = out_s.data.red16;
    assign out_grn16 = out_s.data.grn16;
endmodule

// File: tb/stbd_decoder_asserts.sv
/*
  stbd_decoder_asserts: port-level checks of the texel block decoder.
  Assumes: bound to stbd_decoder; one clock, sys_rst synchronous and active high.
*/
module stbd_decoder_asserts (
    input wire logic clk, // clock
    input wire logic sys_rst, // reset
    input wire logic ce, // clock enable
    input wire logic in_valid, // block offered
    input wire logic in_ready, // block taken
    input wire logic out_valid, // result held
    input wire logic out_ready, // sampler takes
    input wire stbd_pkg::stbd_fmt_t out_fmt, // result format
    input wire logic [15:0][10:0] out_red11, // first channel
    input wire logic [15:0][10:0] out_grn11, // second channel
    input wire logic [15:0][15:0] out_red16, // first channel wide
    input wire logic [15:0][15:0] out_grn16 // second channel wide
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [1:0] occ_r; // blocks held inside
    logic [1:0] occ_nxt; // next holding count
    logic [15:0][15:0] wr_exp; // widened red as it should be
    logic [15:0][15:0] wg_exp; // widened green as it should be
    logic smin; // some texel of either channel reads 11'h400, -1024 if signed
    // widening by replication, negatives through their magnitude
    function automatic logic [15:0] widen(input logic [10:0] x, input logic sgn);
        logic [10:0] m;
        m = -x;
        if (!sgn) return {x, x[10:6]};
        if (!x[10]) return {x, x[9:5]};
        return -{m, m[9:5]};
    endfunction
    // expected wide values and the out-of-range flag
    always_comb begin
        smin = 1'b0;
        for (int p = 0; p < 16; p++) begin
            wr_exp[p] = widen(out_red11[p], out_fmt[0]);
            wg_exp[p] = widen(out_grn11[p], out_fmt[0]);
            smin = smin | (out_red11[p] == 11'h400) | (out_grn11[p] == 11'h400);
        end
    end
    // one in per take, one out per delivery
    always_comb begin
        occ_nxt = occ_r + 2'(in_valid & in_ready) - 2'(out_valid & out_ready);
    end
    always_ff @(posedge clk) begin
        if (sys_rst) occ_r <= 2'h0;
        else occ_r <= occ_nxt;
    end
    sequence taken_s; in_valid && in_ready && !out_valid; endsequence
    sequence stalled_s; out_valid && !out_ready; endsequence
    ce_gate_a: assert property (!ce |-> !in_ready && !out_valid)
        else $error("handshake active while ce low");
    occupancy_a: assert property (in_ready == (ce && occ_r != 2'h3))
        else $error("in_ready disagrees with occupancy");
    reset_clear_a: assert property ($past(sys_rst) |-> !out_valid && out_red11 == '0)
        else $error("output not cleared by reset");
    data_hold_a: assert property (stalled_s ##1 ce |-> out_valid && $stable(out_red11)
        && $stable(out_grn16) && $stable(out_fmt)) else $error("result changed while stalled");
    first_out_a: assert property (taken_s ##1 ce ##1 ce |-> out_valid)
        else $error("result late after take");
    sclamp_a: assert property (out_valid && out_fmt[0] |-> !smin)
        else $error("signed result below -1023");
    grn_zero_a: assert property (out_valid && !out_fmt[1] |-> out_grn11 == '0)
        else $error("second channel nonzero for one-channel block");
    wide_red_a: assert property (out_valid |-> out_red16 == wr_exp)
        else $error("first channel widening wrong");
    wide_grn_a: assert property (out_valid && out_fmt[1] |-> out_grn16 == wg_exp)
        else $error("second channel widening wrong");
endmodule

bind stbd_decoder stbd_decoder_asserts u_chk (.clk, .sys_rst, .ce, .in_valid, .in_ready,
    .out_valid, .out_ready, .out_fmt, .out_red11, .out_grn11, .out_red16, .out_grn16);

// File: tb/stbd_sampler_model.sv
/*
  stbd_sampler_model: sampler side of the result stream, prompt, slow or stalled.
  Assumes: ready changes 1 ns after the rising edge of clk.
*/
module stbd_sampler_model (
    input wire logic clk, // clock
    input wire logic stall, // refuse everything
    input wire logic slow, // accept every other cycle
    output logic out_ready // sampler takes a result
);
    timeunit 1ns;
    timeprecision 100ps;
    logic ph; // alternating phase for slow mode
    // ready pattern, held for a whole cycle; one process owns both signals
    initial begin
        ph = 1'b0;
        out_ready = 1'b0;
        forever begin
            @(posedge clk);
            ph <= #1 ~ph;
            out_ready <= #1 ~stall & (~slow | ph);
        end
    end
endmodule

// File: tb/tb.sv
/*
  tb: self-checking bench of the texel block decoder.
  Assumes: 50 MHz clock; inputs change 1 ns after the rising edge.
*/
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [63:0] W0 = 64'hFF3F_FAC6_88FA_C688; // high base, clamps up
    localparam logic [63:0] W1 = 64'h0012_0539_7705_3977; // zero base, clamps down
    logic clk, sys_rst, ce, in_valid, in_ready, out_valid, out_ready, stall, slow;
    stbd_pkg::stbd_fmt_t in_fmt, out_fmt;
    logic [127:0] in_block; // block bytes
    logic [15:0][10:0] out_red11, out_grn11;
    logic [15:0][15:0] out_red16, out_grn16;
    stbd_pkg::stbd_result_t exp_q[$]; // results still owed
    int n_mismatch, comparisons;
    stbd_decoder dut (.clk, .sys_rst, .ce, .in_valid, .in_ready, .in_fmt, .in_block,
        .out_valid, .out_ready, .out_fmt, .out_red11, .out_grn11, .out_red16, .out_grn16);
    stbd_sampler_model smp (.clk, .stall, .slow, .out_ready);
    // free-running clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic check(input string what, input logic [255:0] exp, input logic [255:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // reference 11-bit texel value
    function automatic logic [10:0] ref11(input logic [63:0] w, input logic sgn, input int p);
        int b, m, mo, s, lo, hi;
        b = sgn ? ((w[63:56] == 8'h80) ? -127 : int'($signed(w[63:56]))) : int'(w[63:56]);
        m = int'(w[55:52]);
        mo = int'($signed(stbd_pkg::MOD_TBL[w[51:48]][w[47-3*p -: 3]]));
        s = b * 8 + (sgn ? 0 : 4) + (m == 0 ? mo : mo * m * 8);
        lo = sgn ? -1023 : 0;
        hi = sgn ? 1023 : 2047;
        if (s > hi) s = hi;
        if (s < lo) s = lo;
        return s[10:0];
    endfunction
    // reference 16-bit widening, arithmetic form
    function automatic logic [15:0] ref16(input logic [10:0] x, input logic sgn);
        int v;
        v = sgn ? int'($signed(x)) : int'(x);
        if (!sgn) return 16'((v << 5) + (v >> 6));
        if (v >= 0) return 16'((v << 5) + (v >> 5));
        v = -v;
        return 16'(-((v << 5) + (v >> 5)));
    endfunction
    // offer one block; leaves in_valid high after the take edge
    task automatic offer(input stbd_pkg::stbd_fmt_t f, input logic [63:0] w0,
            input logic [63:0] w1);
        stbd_pkg::stbd_result_t e;
        logic [127:0] blk;
        int t;
        for (int k = 0; k < 8; k++) begin
            blk[8*k +: 8] = w0[63-8*k -: 8];
            blk[64+8*k +: 8] = w1[63-8*k -: 8];
        end
        e = '0;
        e.fmt = f;
        for (int p = 0; p < 16; p++) begin
            e.red11[p] = ref11(w0, f[0], p);
            e.red16[p] = ref16(e.red11[p], f[0]);
            if (f[1]) begin
                e.grn11[p] = ref11(w1, f[0], p);
                e.grn16[p] = ref16(e.grn11[p], f[0]);
            end
        end
        exp_q.push_back(e);
        in_fmt = f;
        in_block = blk;
        in_valid = 1'b1;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (in_ready !== 1'b1 && t < 100);
        check("taken", 256'(1), 256'(in_ready === 1'b1));
        #1;
    endtask
    // release the input and wait for every owed result
    task automatic drain();
        in_valid = 1'b0;
        repeat (60) if (exp_q.size() != 0) @(posedge clk);
        #1;
        check("undelivered", 256'(0), 256'(exp_q.size()));
    endtask
    // compare each delivered result with the oldest owed one
    always @(posedge clk) begin
        if (sys_rst === 1'b0 && out_valid === 1'b1 && out_ready === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("spare result", 256'(0), 256'(1));
            end else begin
                check("fmt", exp_q[0].fmt, out_fmt);
                check("red11", exp_q[0].red11, out_red11);
                check("grn11", exp_q[0].grn11, out_grn11);
                check("red16", exp_q[0].red16, out_red16);
                check("grn16", exp_q[0].grn16, out_grn16);
                void'(exp_q.pop_front());
            end
        end
    end
    // table 13 by literal: texel p holds index p mod 8, held stalled for inspection
    task automatic t_peek(input stbd_pkg::stbd_fmt_t f, input logic [63:0] w, input int b8,
            input int k, input logic [15:0] w3);
        int t13[8] = '{-1, -2, -3, -10, 0, 1, 2, 9};
        stall = 1'b1;
        offer(f, w, 64'h0);
        in_valid = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        for (int p = 0; p < 16; p++) begin
            check("tbl13", 256'(11'(b8 + k * t13[p % 8])), 256'(out_red11[p]));
        end
        check("wide3", 256'(w3), 256'(out_red16[3]));
        stall = 1'b0;
        drain();
    endtask
    // every format back to back into a slow sampler
    task automatic t_formats();
        slow = 1'b1;
        for (int f = 0; f < 4; f++) offer(stbd_pkg::stbd_fmt_t'(f), W0, W1);
        drain();
        slow = 1'b0;
    endtask
    // fill until refused, freeze with ce, then release the stall
    task automatic t_full();
        stall = 1'b1;
        offer(stbd_pkg::FMT_ONE_SIGNED, W0, 64'h0);
        offer(stbd_pkg::FMT_TWO_UNSIGNED, W1, W0);
        offer(stbd_pkg::FMT_ONE_UNSIGNED, W1, 64'h0);
        check("full ready", 256'(0), 256'(in_ready));
        ce = 1'b0;
        #1;
        check("ce ready", 256'(0), 256'(in_ready));
        check("ce valid", 256'(0), 256'(out_valid));
        @(posedge clk);
        #1 ce = 1'b1;
        fork
            offer(stbd_pkg::FMT_TWO_SIGNED, W0, W1);
            begin
                repeat (4) @(posedge clk);
                #1 stall = 1'b0;
            end
        join
        drain();
    endtask
    // forbidden base code on red; red clamps down only, green clamps up only
    task automatic t_forbid();
        offer(stbd_pkg::FMT_TWO_SIGNED, 64'h80FD_0539_7705_3977, 64'h7FFD_0539_7705_3977);
        drain();
    endtask
    task automatic give_verdict();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // cut a hang short
    initial begin
        #200000;
        n_mismatch++;
        give_verdict();
    end
    // main sequence
    initial begin
        n_mismatch = 0;
        comparisons = 0;
        sys_rst = 1'b1;
        ce = 1'b1;
        in_valid = 1'b0;
        in_fmt = stbd_pkg::FMT_ONE_UNSIGNED;
        in_block = '0;
        stall = 1'b0;
        slow = 1'b0;
        repeat (3) @(posedge clk);
        #1 sys_rst = 1'b0;
        t_peek(stbd_pkg::FMT_ONE_SIGNED, 64'h3C2D_0539_7705_3977, 480, 16, 16'h280A);
        t_peek(stbd_pkg::FMT_ONE_SIGNED, 64'h3C0D_0539_7705_3977, 480, 1, 16'h3ACE);
        t_peek(stbd_pkg::FMT_ONE_UNSIGNED, 64'h672D_0539_7705_3977, 828, 16, 16'h538A);
        t_peek(stbd_pkg::FMT_ONE_UNSIGNED, 64'h670D_0539_7705_3977, 828, 1, 16'h664C);
        t_forbid();
        t_formats();
        t_full();
        give_verdict();
    end
endmodule
